// File: hw/smc_pkg.sv
// Notes on behaviour
// - Write spans the overlap of chip select low and write strobe low.
// - Write data valid 30 ns before write end, held 0 ns after.
// - Host never drives data while the memory drives the bus.
// - Read cycle lasts 70 ns; host samples no earlier than 70 ns after address.
// - Address stable and chip select low 60 ns before write end.
// - Address valid at write start and held 0 ns after write end.
// - Address valid before or as chip select falls on gated reads.
package smc_pkg;

  // Geometry
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;

  // Clock period and documented times, in ns
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_READ_CYCLE_NS = 70;
  localparam int T_ADDR_VALID_NS = 70;
  localparam int T_OE_VALID_NS = 35;
  localparam int T_WRITE_PULSE_NS = 60;
  localparam int T_DATA_SETUP_NS = 30;
  localparam int T_WRITE_CYCLE_NS = 70;
  localparam int T_POWER_DOWN_NS = 70;

  // Least times round up to whole cycles
  function automatic int ceil_cycles(input int ns);
    ceil_cycles = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (ceil_cycles < 1) begin
      ceil_cycles = 1;
    end
  endfunction : ceil_cycles

  localparam int RD_CYCLES = ceil_cycles(T_ADDR_VALID_NS);
  localparam int WR_CYCLES = ceil_cycles(T_WRITE_PULSE_NS);
  localparam int WR_SETUP_CYCLES = ceil_cycles(T_DATA_SETUP_NS);
  localparam int RECOVER_CYCLES = 1;
  localparam int CNT_W = 4;

  // Controller sequence states
  typedef enum logic [2:0] {
    SMC_IDLE,
    SMC_READ,
    SMC_WRITE,
    SMC_RECOVER
  } smc_state_t;

endpackage : smc_pkg

// File: hw/smc_host.sv
`timescale 1ns/1ps
module smc_host
  import smc_pkg::*;
#(
  parameter int RD_WAIT = RD_CYCLES,
  parameter int WR_WAIT = WR_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // User request
  input wire logic req,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  // Memory pins
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_cs_n,
  output logic mem_oe_n,
  output logic mem_we_n,
  output logic [DATA_W-1:0] mem_dq_out,
  output logic mem_dq_oe,
  input wire logic [DATA_W-1:0] mem_dq_in
);

  // Sequencer state and its cycle counter
  smc_state_t state;
  logic [CNT_W-1:0] cnt;

  // Three stage capture of the data pins
  logic [DATA_W-1:0] dq_s1;
  logic [DATA_W-1:0] dq_s2;
  logic [DATA_W-1:0] dq_s3;

  // Decoded events of the current cycle
  logic take;
  logic bus_settled;
  logic rd_done;
  logic wr_done;
  logic rec_done;

  // Read window covers access time plus three synchroniser stages
  localparam logic [CNT_W-1:0] RD_LAST = CNT_W'(RD_WAIT + 2);
  // Write strobe stays low for WR_WAIT cycles, counted from zero
  localparam logic [CNT_W-1:0] WR_LAST = CNT_W'(WR_WAIT - 1);
  // Idle strobes between accesses, counted from zero
  localparam logic [CNT_W-1:0] REC_LAST = CNT_W'(RECOVER_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////
  // Counter end test, shared by every timed phase
  function automatic logic count_hit(
    input logic [CNT_W-1:0] value,
    input logic [CNT_W-1:0] last
  );
    count_hit = (value == last);
  endfunction : count_hit

  ////////////////////////////////////////////////////////////////////////
  // Event decode
  // A request is taken only in idle while ready stands
  assign take = (state == SMC_IDLE) && req && req_ready;
  // Last two stages agree: the pin value has held steady for a cycle
  assign bus_settled = (dq_s2 == dq_s3);
  // Read ends only once the window is over and the capture agrees
  assign rd_done = (state == SMC_READ) && count_hit(cnt, RD_LAST) && bus_settled;
  // Write pulse covers 60 ns address and select setup
  assign wr_done = (state == SMC_WRITE) && count_hit(cnt, WR_LAST);
  // Recovery keeps all strobes high for a while
  assign rec_done = (state == SMC_RECOVER) && count_hit(cnt, REC_LAST);

  ////////////////////////////////////////////////////////////////////////
  // Data pin synchroniser; only the second stage reads the first
  always_ff @(posedge clk) begin
    dq_s1 <= mem_dq_in;
    dq_s2 <= dq_s1;
    dq_s3 <= dq_s2;
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= SMC_IDLE;
    end else begin
      unique case (state)
        SMC_IDLE: begin
          if (take && req_write) begin
            state <= SMC_WRITE;
          end else if (take) begin
            state <= SMC_READ;
          end
        end
        SMC_READ: begin
          if (rd_done) begin
            state <= SMC_RECOVER;
          end
        end
        SMC_WRITE: begin
          if (wr_done) begin
            state <= SMC_RECOVER;
          end
        end
        SMC_RECOVER: begin
          if (rec_done) begin
            state <= SMC_IDLE;
          end
        end
        default: begin
          state <= SMC_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Phase counter; it waits at the read end for a settled bus
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt <= '0;
    end else if (state == SMC_IDLE || rd_done || wr_done || rec_done) begin
      cnt <= '0;
    end else if (state == SMC_READ && count_hit(cnt, RD_LAST)) begin
      // A late bus stretches the read rather than returning a torn byte
      cnt <= cnt;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ready to the user; low from take until one cycle after idle comes back
  always_ff @(posedge clk) begin
    if (!resetn) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (state == SMC_IDLE) && !take;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address pins; set on take, held through recovery
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mem_addr <= '0;
    end else if (take) begin
      mem_addr <= req_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Chip select; high whenever idle keeps the memory in standby
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mem_cs_n <= 1'b1;
    end else if (take) begin
      mem_cs_n <= 1'b0;
    end else if (rd_done || wr_done) begin
      mem_cs_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output enable; low only for reads
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mem_oe_n <= 1'b1;
    end else if (take) begin
      // Stays high on writes so the memory never drives
      mem_oe_n <= req_write;
    end else if (rd_done) begin
      mem_oe_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write strobe; rises on the same edge as chip select
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mem_we_n <= 1'b1;
    end else if (take) begin
      mem_we_n <= !req_write;
    end else if (wr_done) begin
      mem_we_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write data; unchanged from take until after the write edge
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mem_dq_out <= '0;
    end else if (take && req_write) begin
      mem_dq_out <= req_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data drive enable; released one cycle past the write edge for hold
  // time, never on during reads
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mem_dq_oe <= 1'b0;
    end else if (take) begin
      mem_dq_oe <= req_write;
    end else if (state == SMC_RECOVER) begin
      mem_dq_oe <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read capture; only a settled byte is handed over
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_done;
    end
  end

  // Read byte stands until the next read completes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_data <= '0;
    end else if (rd_done) begin
      rd_data <= dq_s3;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Limitations
  // Reads wait on the settled capture, so a bus that never settles holds
  // the read open; a real memory drives a steady byte while selected.
  // Writes always use the form with output enable high, trading a
  // little flexibility for a bus that can never be fought over.
  // One access at a time: no pipelining of address and data phases.

endmodule : smc_host

// File: verif/smc_host_monitor.sv
`timescale 1ns/1ps
module smc_host_monitor
  import smc_pkg::*;
(
  // Pins watched
  input wire logic clk, resetn, mem_cs_n, mem_oe_n, mem_we_n, mem_dq_oe, rd_valid,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_dq_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Write strobe low for at least 60 ns
  sequence wr_low_s;
    !mem_we_n [*3];
  endsequence
  no_contend_a: assert property (mem_dq_oe |-> mem_oe_n) else $error("host drives during read");
  wr_sel_a: assert property (!mem_we_n |-> !mem_cs_n) else $error("write strobe unselected");
  same_rise_a: assert property ($rose(mem_we_n) |-> $rose(mem_cs_n)) else $error("strobes split");
  data_hold_a: assert property ($rose(mem_we_n) |-> mem_dq_oe) else $error("data dropped early");
  wr_pulse_a: assert property ($fell(mem_we_n) |-> wr_low_s) else $error("write too short");
  data_still_a: assert property (!mem_we_n |=> $stable(mem_dq_out)) else $error("data moved");
  addr_hold_a: assert property (!mem_cs_n |=> $stable(mem_addr)) else $error("address moved");
  rd_wait_a: assert property (rd_valid |-> !$past(mem_oe_n, 6)) else $error("read too early");
endmodule : smc_host_monitor
////////////////////////////////////////////////////////////
bind smc_host smc_host_monitor mon_u (.*);

// File: verif/smc_sram_model.sv
`timescale 1ns/1ps
module smc_sram_model
  import smc_pkg::*;
#(
  parameter int DLY_NS = 0
) (
  // Strobes and buses
  input wire logic cs_n, oe_n, we_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq,
  output logic [DATA_W-1:0] q,
  output logic drv
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]]; // Sparse 512K x 8 store
  logic [DATA_W-1:0] last;
  // Store during overlap; deselected ignores all
  always @* if (!cs_n && !we_n) mem[addr] = dq;
  // Drive only in read mode
  assign drv = !cs_n && !oe_n && we_n;
  // Follow address while driving in read mode
  always @(drv or addr or cs_n or we_n) if (drv) last = mem[addr];
  // Slow answer inside 70 ns; floating lines show inverse
  assign #(DLY_NS) q = drv ? last : ~last;
endmodule : smc_sram_model

// File: verif/smc_host_tb.sv
`timescale 1ns/1ps
module smc_host_tb
  import smc_pkg::*;
;
  logic clk, resetn, req, req_write, req_ready, rd_valid, cs_n, oe_n, we_n, dq_oe, drv;
  logic [ADDR_W-1:0] req_addr, mem_addr;
  logic [DATA_W-1:0] req_wdata, rd_data, dq_out, dq_in, q;
  int fail_count = 0;
  int checks_done = 0;
  // Wire level from both drivers
  assign dq_in = dq_oe ? dq_out : q;
  smc_host dut_u (.clk(clk), .resetn(resetn), .req(req), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .mem_addr(mem_addr), .mem_cs_n(cs_n), .mem_oe_n(oe_n), .mem_we_n(we_n),
    .mem_dq_out(dq_out), .mem_dq_oe(dq_oe), .mem_dq_in(dq_in));
  smc_sram_model #(.DLY_NS(60)) mem_u (.cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .addr(mem_addr),
    .dq(dq_in), .q(q), .drv(drv));
  ////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("fails %0d checks %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic cmp8(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t read %h expected %h", $time, got, exp);
    end
  endtask : cmp8
  // Bounded wait, a hang closes the run
  task automatic wait_for(ref logic sig);
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (sig === 1'b1) break;
    end
    if (n == 50) begin
      fail_count++;
      $display("ERROR %0t handshake hang", $time);
      close_out();
    end
  endtask : wait_for
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    wait_for(req_ready);
    req <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    req <= 1'b0;
  endtask : acc
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    acc(1'b0, a, 8'h00);
    wait_for(rd_valid);
    cmp8(rd_data, e);
  endtask : rd
  ////////////////////////////////////////////////////////////
  // Both ends of the address range
  task automatic sc_bounds;
    acc(1'b1, 19'h00000, 8'ha5);
    acc(1'b1, 19'h7ffff, 8'h3c);
    rd(19'h00000, 8'ha5);
    rd(19'h7ffff, 8'h3c);
  endtask : sc_bounds
  // Overwrite, then two reads back to back
  task automatic sc_rewrite;
    acc(1'b1, 19'h12345, 8'h01);
    acc(1'b1, 19'h12345, 8'hfe);
    rd(19'h12345, 8'hfe);
    rd(19'h12345, 8'hfe);
  endtask : sc_rewrite
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {resetn, req, req_write, req_addr, req_wdata} = '0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    sc_bounds();
    sc_rewrite();
    close_out();
  end
endmodule : smc_host_tb
